/* File: rtl/sfe_defs.svh */
`ifndef SFE_DEFS_SVH
`define SFE_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFE_CLK_PERIOD_NS 100
`define SFE_REF_LAT_NS 11500
`define SFE_REF_MAX_CYC (`SFE_REF_LAT_NS / `SFE_CLK_PERIOD_NS)
`define SFE_REF_URGENT_CYC (`SFE_REF_MAX_CYC - 2 * `SFE_VID_BURST_WORDS)

// ----------------------------------------
// Burst shapes
// ----------------------------------------
`define SFE_VID_BURST_WORDS 16
`define SFE_QUAD_WORDS 4
`define SFE_QUAD_BYTES 16

// ----------------------------------------
// Address fields
// ----------------------------------------
`define SFE_QTAG_LSB 4
`define SFE_WORD_LSB 2
`define SFE_REGION_LSB 26

// ----------------------------------------
// Reset values and default widths
// ----------------------------------------
`define SFE_FLUSH_RST 8'h00
`define SFE_REF_PERIOD_W 12
`define SFE_FLUSH_W 8

`endif

/* File: rtl/sfe_pkg.sv */
package sfe_pkg;

    typedef enum logic [1:0] {
        SFE_CMD_READ = 2'h0,
        SFE_CMD_WRITE = 2'h1,
        SFE_CMD_REFRESH = 2'h2
    } sfe_cmd_t;

    typedef enum logic [1:0] {
        SFE_SZ_BYTE = 2'h0,
        SFE_SZ_HALF = 2'h1,
        SFE_SZ_WORD = 2'h2
    } sfe_size_t;

    typedef enum logic [2:0] {
        SFE_ST_IDLE,
        SFE_ST_VCMD,
        SFE_ST_VDAT,
        SFE_ST_REF0,
        SFE_ST_REF1,
        SFE_ST_RCMD,
        SFE_ST_RDAT,
        SFE_ST_WCMD
    } sfe_state_t;

endpackage : sfe_pkg

/* File: rtl/sfe_ref_timer.sv */
`timescale 1ns/10ps
`include "sfe_defs.svh"

module sfe_ref_timer #(
    parameter int PW = `SFE_REF_PERIOD_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic [PW-1:0] period,
    input wire logic served,
    output logic pending,
    output logic urgent
);

    localparam logic [7:0] URGENT_CYC = 8'(`SFE_REF_URGENT_CYC);

    logic [PW-1:0] cnt_r;
    logic tick;
    logic [7:0] wait_r;

    assign tick = enable && (cnt_r == '0);

    // ----------------------------------------
    // Period counter
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst || !enable)
            cnt_r <= period;
        else if (tick)
            cnt_r <= period;
        else
            cnt_r <= cnt_r - 1'b1;
    end

    // Tick wins over a simultaneous service
    always_ff @(posedge clk)
    begin
        if (srst)
            pending <= 1'b0;
        else if (tick)
            pending <= 1'b1;
        else if (served)
            pending <= 1'b0;
    end

    // ----------------------------------------
    // Waiting time of a pending refresh
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst || !pending || served)
            wait_r <= 8'h00;
        else if (wait_r != 8'hff)
            wait_r <= wait_r + 8'h01;
    end

    assign urgent = pending && (wait_r >= URGENT_CYC);

endmodule : sfe_ref_timer

/* File: rtl/sfe_front_end.sv */
`timescale 1ns/10ps
`include "sfe_defs.svh"

module sfe_front_end #(
    parameter int RPW = `SFE_REF_PERIOD_W,
    parameter int FW = `SFE_FLUSH_W,
    parameter logic [5:0] VID_REGION = 6'h01
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic wbuf_en,
    input wire logic refresh_en,
    input wire logic [RPW-1:0] refresh_period,
    input wire logic [FW-1:0] flush_timeout,
    input wire logic m_req,
    input wire logic m_sel,
    input wire logic m_write,
    input wire logic [25:0] m_addr,
    input wire logic [1:0] m_size,
    input wire logic [31:0] m_wdata,
    output logic m_ack,
    output logic m_blast,
    output logic [31:0] m_rdata,
    input wire logic v_req,
    input wire logic v_write,
    input wire logic [31:0] v_addr,
    output logic v_grant,
    output logic v_err,
    output logic v_rvalid,
    output logic v_last,
    output logic [31:0] v_rdata,
    output logic s_cmd_valid,
    input wire logic s_cmd_ready,
    output sfe_pkg::sfe_cmd_t s_cmd_kind,
    output logic s_cmd_dev,
    output logic [4:0] s_cmd_words,
    output logic [25:4] s_cmd_addr,
    output logic [127:0] s_cmd_wdata,
    output logic [15:0] s_cmd_wmask,
    input wire logic s_rvalid,
    input wire logic [31:0] s_rdata,
    output logic ref_pending
);

    localparam logic [4:0] VID_LAST = 5'(`SFE_VID_BURST_WORDS - 1);
    localparam logic [4:0] QUAD_LAST = 5'(`SFE_QUAD_WORDS - 1);
    localparam logic [FW-1:0] FLUSH_RST = FW'(`SFE_FLUSH_RST);

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
        logic [3:0] r;
        r = 4'h0;
        case (sz)
            sfe_pkg::SFE_SZ_WORD: r = 4'hf;
            sfe_pkg::SFE_SZ_HALF: r = a[1] ? 4'hc : 4'h3;
            default: r = 4'(4'h1 << a);
        endcase
        return r;
    endfunction : lanes

    // Beat that ends on the quad-word boundary
    function automatic logic quad_end(input logic [1:0] sz, input logic [3:0] a);
        logic r;
        r = 1'b0;
        case (sz)
            sfe_pkg::SFE_SZ_WORD: r = (a[3:2] == 2'h3);
            sfe_pkg::SFE_SZ_HALF: r = (a[3:1] == 3'h7);
            default: r = (a == 4'hf);
        endcase
        return r;
    endfunction : quad_end

    function automatic logic [31:0] replicate(input logic [31:0] w, input logic [1:0] sz,
                                              input logic [1:0] a);
        logic [31:0] r;
        r = w;
        case (sz)
            sfe_pkg::SFE_SZ_WORD: r = w;
            sfe_pkg::SFE_SZ_HALF: r = a[1] ? {2{w[31:16]}} : {2{w[15:0]}};
            default: r = {4{w[8*a +: 8]}};
        endcase
        return r;
    endfunction : replicate

    // ----------------------------------------
    // State
    // ----------------------------------------
    sfe_pkg::sfe_state_t st_r;
    logic [4:0] beat_r;
    logic [7:0] buf_data_r [0:1][0:15];
    logic [15:0] buf_mask_r [0:1];
    logic [25:4] buf_tag_r [0:1];
    logic merge_idx_r;
    logic merge_valid_r;
    logic drain_valid_r;
    logic [FW-1:0] flush_cnt_r;
    logic [31:0] line_r [0:3];
    logic [25:4] line_tag_r;
    logic line_valid_r;
    logic m_ack_r;
    logic ref_served;
    logic ref_urgent;

    // ----------------------------------------
    // Main bus request decode
    // ----------------------------------------
    logic [25:4] qtag;
    logic mreq;
    logic rd_hit;
    logic merge_hit;
    logic drain_hit;
    logic rd_accept;
    logic rd_need;
    logic rd_trig;
    logic miss_trig;
    logic tmo_trig;
    logic dis_trig;
    logic swap;
    logic wr_accept;
    logic wr_fresh;
    logic wr_tgt;
    logic vid_hit;
    logic [3:0] wr_lanes;

    assign qtag = m_addr[25:4];
    assign mreq = m_req && m_sel && !m_ack_r;
    assign rd_hit = line_valid_r && (line_tag_r == qtag);
    assign merge_hit = merge_valid_r && (buf_tag_r[merge_idx_r] == qtag);
    assign drain_hit = drain_valid_r && (buf_tag_r[!merge_idx_r] == qtag);
    assign rd_accept = mreq && !m_write && rd_hit;
    assign rd_need = mreq && !m_write && !rd_hit && !merge_hit && !drain_hit;
    assign rd_trig = mreq && !m_write && !rd_hit && merge_hit;
    assign miss_trig = mreq && m_write && merge_valid_r && !merge_hit;
    assign tmo_trig = merge_valid_r && (flush_cnt_r == '0);
    assign dis_trig = merge_valid_r && !wbuf_en;
    assign swap = !drain_valid_r && (rd_trig || miss_trig || tmo_trig || dis_trig);
    assign wr_accept = mreq && m_write && (!merge_valid_r || (merge_hit && wbuf_en) || swap);
    assign wr_fresh = !merge_valid_r || swap;
    assign wr_tgt = swap ? !merge_idx_r : merge_idx_r;
    assign vid_hit = (v_addr[31:`SFE_REGION_LSB] == VID_REGION);
    assign wr_lanes = lanes(m_size, m_addr[1:0]);

    // ----------------------------------------
    // Refresh request timer
    // ----------------------------------------
    assign ref_served = (st_r == sfe_pkg::SFE_ST_REF1) && s_cmd_ready;

    sfe_ref_timer #(
        .PW(RPW)
    ) u_ref_timer (
        .clk(clk),
        .srst(srst),
        .enable(refresh_en),
        .period(refresh_period),
        .served(ref_served),
        .pending(ref_pending),
        .urgent(ref_urgent)
    );

    // ----------------------------------------
    // Arbiter state machine
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_r <= sfe_pkg::SFE_ST_IDLE;
            beat_r <= 5'h00;
        end
        else
        begin
            case (st_r)
                sfe_pkg::SFE_ST_IDLE:
                begin
                    beat_r <= 5'h00;
                    if (ref_urgent)
                        st_r <= sfe_pkg::SFE_ST_REF0;
                    else if (v_req && !v_write && vid_hit && !v_grant)
                        st_r <= sfe_pkg::SFE_ST_VCMD;
                    else if (ref_pending && !(v_req && !v_write && vid_hit))
                        st_r <= sfe_pkg::SFE_ST_REF0;
                    else if (drain_valid_r && !v_req)
                        st_r <= sfe_pkg::SFE_ST_WCMD;
                    else if (rd_need && !v_req)
                        st_r <= sfe_pkg::SFE_ST_RCMD;
                end
                sfe_pkg::SFE_ST_VCMD:
                    if (s_cmd_ready)
                        st_r <= sfe_pkg::SFE_ST_VDAT;
                sfe_pkg::SFE_ST_VDAT:
                    if (s_rvalid)
                    begin
                        beat_r <= beat_r + 5'h01;
                        if (beat_r == VID_LAST)
                            st_r <= sfe_pkg::SFE_ST_IDLE;
                    end
                sfe_pkg::SFE_ST_REF0:
                    if (s_cmd_ready)
                        st_r <= sfe_pkg::SFE_ST_REF1;
                sfe_pkg::SFE_ST_REF1:
                    if (s_cmd_ready)
                        st_r <= sfe_pkg::SFE_ST_IDLE;
                sfe_pkg::SFE_ST_RCMD:
                    if (s_cmd_ready)
                        st_r <= sfe_pkg::SFE_ST_RDAT;
                sfe_pkg::SFE_ST_RDAT:
                    if (s_rvalid)
                    begin
                        beat_r <= beat_r + 5'h01;
                        if (beat_r == QUAD_LAST)
                            st_r <= sfe_pkg::SFE_ST_IDLE;
                    end
                sfe_pkg::SFE_ST_WCMD:
                    if (s_cmd_ready)
                        st_r <= sfe_pkg::SFE_ST_IDLE;
                default:
                    st_r <= sfe_pkg::SFE_ST_IDLE;
            endcase
        end
    end

    assign s_cmd_valid = (st_r == sfe_pkg::SFE_ST_VCMD) || (st_r == sfe_pkg::SFE_ST_REF0)
        || (st_r == sfe_pkg::SFE_ST_REF1) || (st_r == sfe_pkg::SFE_ST_RCMD)
        || (st_r == sfe_pkg::SFE_ST_WCMD);

    // ----------------------------------------
    // SDRAM command fields
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_cmd_kind <= sfe_pkg::SFE_CMD_READ;
            s_cmd_dev <= 1'b0;
            s_cmd_words <= 5'h00;
            s_cmd_addr <= '0;
            s_cmd_wdata <= '0;
            s_cmd_wmask <= 16'h0000;
        end
        else if (st_r == sfe_pkg::SFE_ST_IDLE)
        begin
            s_cmd_dev <= 1'b0;
            if (ref_urgent || (ref_pending && !(v_req && !v_write && vid_hit && !v_grant)))
                s_cmd_kind <= sfe_pkg::SFE_CMD_REFRESH;
            else if (v_req)
            begin
                s_cmd_kind <= sfe_pkg::SFE_CMD_READ;
                s_cmd_words <= VID_LAST + 5'h01;
                s_cmd_addr <= v_addr[25:4];
            end
            else if (drain_valid_r)
            begin
                s_cmd_kind <= sfe_pkg::SFE_CMD_WRITE;
                s_cmd_words <= QUAD_LAST + 5'h01;
                s_cmd_addr <= buf_tag_r[!merge_idx_r];
                s_cmd_wmask <= buf_mask_r[!merge_idx_r];
                for (int b = 0; b < `SFE_QUAD_BYTES; b++)
                    s_cmd_wdata[8*b +: 8] <= buf_data_r[!merge_idx_r][b];
            end
            else
            begin
                s_cmd_kind <= sfe_pkg::SFE_CMD_READ;
                s_cmd_words <= QUAD_LAST + 5'h01;
                s_cmd_addr <= qtag;
            end
        end
        else if ((st_r == sfe_pkg::SFE_ST_REF0) && s_cmd_ready)
            s_cmd_dev <= 1'b1;
    end

    // ----------------------------------------
    // Video bus answers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            v_grant <= 1'b0;
            v_err <= 1'b0;
            v_rvalid <= 1'b0;
            v_last <= 1'b0;
            v_rdata <= 32'h0000_0000;
        end
        else
        begin
            v_grant <= (st_r == sfe_pkg::SFE_ST_IDLE) && !ref_urgent && v_req && !v_write && vid_hit
                && !v_grant;
            v_err <= (st_r == sfe_pkg::SFE_ST_IDLE) && v_req && (v_write || !vid_hit) && !v_err;
            v_rvalid <= (st_r == sfe_pkg::SFE_ST_VDAT) && s_rvalid;
            v_last <= (st_r == sfe_pkg::SFE_ST_VDAT) && s_rvalid && (beat_r == VID_LAST);
            if ((st_r == sfe_pkg::SFE_ST_VDAT) && s_rvalid)
                v_rdata <= s_rdata;
        end
    end

    // ----------------------------------------
    // Read line fed by main-bus quad bursts
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            line_valid_r <= 1'b0;
            line_tag_r <= '0;
            for (int i = 0; i < `SFE_QUAD_WORDS; i++)
                line_r[i] <= 32'h0000_0000;
        end
        else
        begin
            if ((st_r == sfe_pkg::SFE_ST_IDLE) && rd_need && !v_req && !ref_pending && !drain_valid_r)
            begin
                line_valid_r <= 1'b0;
                line_tag_r <= qtag;
            end
            else if ((st_r == sfe_pkg::SFE_ST_RDAT) && s_rvalid)
            begin
                line_r[beat_r[1:0]] <= s_rdata;
                if (beat_r == QUAD_LAST)
                    line_valid_r <= 1'b1;
            end
            else if (wr_accept && (qtag == line_tag_r))
                line_valid_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Main bus answers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            m_ack_r <= 1'b0;
            m_blast <= 1'b0;
            m_rdata <= 32'h0000_0000;
        end
        else
        begin
            m_ack_r <= rd_accept || wr_accept;
            m_blast <= (rd_accept || wr_accept) && quad_end(m_size, m_addr[3:0]);
            if (rd_accept)
                m_rdata <= replicate(line_r[m_addr[3:2]], m_size, m_addr[1:0]);
        end
    end

    assign m_ack = m_ack_r;

    // ----------------------------------------
    // Ping-pong buffer control
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            merge_idx_r <= 1'b0;
            merge_valid_r <= 1'b0;
            drain_valid_r <= 1'b0;
            buf_tag_r[0] <= '0;
            buf_tag_r[1] <= '0;
        end
        else
        begin
            if (swap)
            begin
                merge_idx_r <= !merge_idx_r;
                drain_valid_r <= 1'b1;
            end
            else if ((st_r == sfe_pkg::SFE_ST_WCMD) && s_cmd_ready)
                drain_valid_r <= 1'b0;
            if (wr_accept)
            begin
                merge_valid_r <= 1'b1;
                buf_tag_r[wr_tgt] <= qtag;
            end
            else if (swap)
                merge_valid_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Merging of byte lanes
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            buf_mask_r[0] <= 16'h0000;
            buf_mask_r[1] <= 16'h0000;
            for (int h = 0; h < 2; h++)
                for (int b = 0; b < `SFE_QUAD_BYTES; b++)
                    buf_data_r[h][b] <= 8'h00;
        end
        else if (wr_accept)
        begin
            buf_mask_r[wr_tgt] <= (wr_fresh ? 16'h0000 : buf_mask_r[wr_tgt])
                | (16'(wr_lanes) << {m_addr[3:2], 2'h0});
            for (int b = 0; b < 4; b++)
                if (wr_lanes[b])
                    buf_data_r[wr_tgt][{m_addr[3:2], 2'(b)}] <= m_wdata[8*b +: 8];
        end
    end

    // ----------------------------------------
    // Flush timer
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            flush_cnt_r <= FLUSH_RST;
        else if (wr_accept)
            flush_cnt_r <= flush_timeout;
        else if (merge_valid_r && (flush_cnt_r != '0))
            flush_cnt_r <= flush_cnt_r - 1'b1;
    end

endmodule : sfe_front_end

/* File: sim/sfe_props_properties.sv */
`timescale 1ns/10ps
module sfe_props #(
    parameter logic [5:0] VID_REGION = 6'h01
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic m_req,
    input wire logic m_write,
    input wire logic [25:0] m_addr,
    input wire logic [1:0] m_size,
    input wire logic m_ack,
    input wire logic m_blast,
    input wire logic [31:0] m_rdata,
    input wire logic v_write,
    input wire logic [31:0] v_addr,
    input wire logic v_grant,
    input wire logic v_rvalid,
    input wire logic v_last,
    input wire logic s_cmd_valid,
    input wire logic s_cmd_ready,
    input wire sfe_pkg::sfe_cmd_t s_cmd_kind,
    input wire logic s_cmd_dev,
    input wire logic [4:0] s_cmd_words,
    input wire logic [25:4] s_cmd_addr,
    input wire logic ref_pending
);
    logic [5:0] v_region;
    assign v_region = v_addr[31:26];
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // Bus and refresh checks
    // ----------------------------------------
    main_blast_a: assert property (m_ack && m_req |->
        m_blast == ((m_addr[3:0] | (m_size == 2'h2 ? 4'h3 : {3'h0, m_size[0]})) == 4'hf))
        else $error("blast flag wrong");
    byte_repl_a: assert property (m_ack && m_req && !m_write && m_size == 2'h0 |->
        m_rdata == {4{m_rdata[7:0]}}) else $error("byte not replicated");
    cmd_hold_a: assert property (s_cmd_valid && !s_cmd_ready |=>
        s_cmd_valid && $stable(s_cmd_kind) && $stable(s_cmd_addr)) else $error("command dropped");
    main_quad_a: assert property (s_cmd_valid && s_cmd_kind == sfe_pkg::SFE_CMD_WRITE |->
        s_cmd_words == 5'h04) else $error("write burst not a quad");
    vid_stream_a: assert property (v_rvalid && !v_last |=> v_rvalid)
        else $error("gap in video burst");
    vid_accept_a: assert property (v_grant |-> !$past(v_write) && $past(v_region) == VID_REGION)
        else $error("video burst wrongly granted");
    ref_pair_a: assert property (s_cmd_ready && s_cmd_kind == sfe_pkg::SFE_CMD_REFRESH && !s_cmd_dev
        |=> s_cmd_valid && s_cmd_kind == sfe_pkg::SFE_CMD_REFRESH && s_cmd_dev) else $error("refresh pair split");
    ref_lat_a: assert property ($rose(ref_pending) |-> ##[0:115]
        (s_cmd_valid && s_cmd_kind == sfe_pkg::SFE_CMD_REFRESH)) else $error("refresh too late");
    cover property (v_grant);
    cover property (m_ack && m_blast);
    cover property (s_cmd_ready && s_cmd_dev && s_cmd_kind == sfe_pkg::SFE_CMD_REFRESH);
endmodule : sfe_props

/* File: sim/sfe_sdram_model.sv */
`timescale 1ns/10ps
module sfe_sdram_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic slow,
    input wire logic s_cmd_valid,
    output logic s_cmd_ready,
    input wire sfe_pkg::sfe_cmd_t s_cmd_kind,
    input wire logic [4:0] s_cmd_words,
    input wire logic [25:4] s_cmd_addr,
    input wire logic [127:0] s_cmd_wdata,
    input wire logic [15:0] s_cmd_wmask,
    output logic s_rvalid,
    output logic [31:0] s_rdata
);
    logic [31:0] mem [int];
    logic [31:0] v;
    logic [15:0] last_mask;
    int n_wr, n_ref, wr_at_rd, left, wa, dly, b;
    function automatic logic [31:0] rd(input int a);
        return mem.exists(a) ? mem[a] : 32'(a) ^ 32'h3c5a_0000;
    endfunction : rd
    // Busy while streaming; a command accepted in slow mode stalls the next one for 3 cycles
    assign s_cmd_ready = s_cmd_valid && left == 0 && dly == 0;
    always @(posedge clk)
    begin
        if (srst)
        begin
            left <= 0;
            dly <= 0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0;
        end
        else
        begin
            s_rvalid <= left > 0;
            s_rdata <= left > 0 ? rd(wa) : ~s_rdata;
            if (left > 0)
            begin
                wa <= wa + 1;
                left <= left - 1;
            end
            if (s_cmd_valid && dly > 0)
                dly <= dly - 1;
            if (s_cmd_ready)
            begin
                dly <= slow ? 3 : 0;
                n_ref += s_cmd_kind == sfe_pkg::SFE_CMD_REFRESH;
                if (s_cmd_kind == sfe_pkg::SFE_CMD_READ)
                begin
                    wr_at_rd = n_wr;
                    left <= int'(s_cmd_words);
                    wa <= int'({s_cmd_addr, 2'b00});
                end
                if (s_cmd_kind == sfe_pkg::SFE_CMD_WRITE)
                begin
                    n_wr++;
                    last_mask = s_cmd_wmask;
                    for (b = 0; b < 16; b++)
                        if (s_cmd_wmask[b])
                        begin
                            v = rd({s_cmd_addr, 2'b00} + b / 4);
                            v[8 * (b % 4) +: 8] = s_cmd_wdata[8 * b +: 8];
                            mem[{s_cmd_addr, 2'b00} + b / 4] = v;
                        end
                end
            end
        end
    end
endmodule : sfe_sdram_model

/* File: sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clk, srst, wbuf_en, refresh_en, m_req, m_sel, m_write, v_req, v_write, slow, vgo;
    logic m_ack, m_blast, v_grant, v_err, v_rvalid, v_last, s_cmd_valid, s_cmd_ready, s_cmd_dev, s_rvalid;
    logic ref_pending;
    logic [11:0] refresh_period;
    logic [7:0] flush_timeout;
    logic [25:0] m_addr, ad;
    logic [1:0] m_size, sz;
    logic [31:0] m_wdata, m_rdata, v_addr, v_rdata, s_rdata, va;
    sfe_pkg::sfe_cmd_t s_cmd_kind;
    logic [4:0] s_cmd_words;
    logic [25:4] s_cmd_addr;
    logic [127:0] s_cmd_wdata;
    logic [15:0] s_cmd_wmask;
    logic [31:0] sh [int];
    int error_cnt, checks, n, it;
    sfe_front_end #(.RPW(12), .FW(8)) DUT (.*);
    sfe_sdram_model u_mem (.*);
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] exp_w(input int a);
        return sh.exists(a) ? sh[a] : 32'(a) ^ 32'h3c5a_0000;
    endfunction : exp_w
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic chk_d(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_d
    task automatic chk_n(input int g, input int e);
        checks++;
        if (g != e)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_n
    task automatic wt(input int s);
        int i;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while ((s == 0 ? m_ack : s == 1 ? v_grant | v_err : v_rvalid) !== 1'b1 && i < 2000);
        if (i >= 2000)
        begin
            error_cnt++;
            end_sim;
        end
    endtask : wt
    task automatic mx(input logic w, input logic [25:0] a, input logic [1:0] z, input logic [31:0] d);
        logic [31:0] e;
        int i;
        m_req <= 1'b1;
        m_write <= w;
        m_addr <= a;
        m_size <= z;
        m_wdata <= d;
        wt(0);
        m_req <= 1'b0;
        e = exp_w(int'(a[25:2]));
        chk_d({31'h0, m_blast}, {31'h0, (a[3:0] | (z == 2'h2 ? 4'h3 : {3'h0, z[0]})) == 4'hf});
        if (w)
        begin
            for (i = 0; i < 4; i++)
                if (z == 2'h2 || (z == 2'h1 && i[1] == a[1]) || (z == 2'h0 && i == a[1:0]))
                    e[8 * i +: 8] = d[8 * i +: 8];
            sh[int'(a[25:2])] = e;
        end
        else
        begin
            if (z == 2'h1)
                e = {2{e[16 * a[1] +: 16]}};
            if (z == 2'h0)
                e = {4{e[8 * a[1:0] +: 8]}};
            chk_d(m_rdata, e);
        end
        @(posedge clk);
    endtask : mx
    task automatic vr(input logic [31:0] a, input logic w);
        int k;
        v_req <= 1'b1;
        v_write <= w;
        v_addr <= a;
        wt(1);
        v_req <= 1'b0;
        chk_d({31'h0, v_err}, {31'h0, w || a[31:26] != 6'h01});
        for (k = 0; k < 16 && w == 1'b0 && a[31:26] == 6'h01; k++)
        begin
            wt(2);
            chk_d(v_rdata, exp_w(int'(a[25:2]) + k));
            chk_d({31'h0, v_last}, {31'h0, k == 15});
        end
        @(posedge clk);
    endtask : vr
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        {srst, m_sel, wbuf_en, refresh_en, m_req, m_write, v_req, v_write, slow} = 9'h180;
        {refresh_period, flush_timeout, m_addr, m_size, m_wdata, v_addr} = '0;
        refresh_period = 12'h063;
        flush_timeout = 8'hff;
        void'($urandom(32'h43be10ea));
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        n = u_mem.n_wr;
        mx(1'b1, 26'h40, 2'h2, 32'h1234_5678);
        repeat (20) @(posedge clk);
        chk_n(u_mem.n_wr, n + 1);
        chk_d(32'(u_mem.last_mask), 32'h000f);
        $display("test unbuffered write done");
        m_sel <= 1'b0;
        m_req <= 1'b1;
        repeat (6)
        begin
            @(posedge clk);
            chk_d({31'h0, m_ack}, 32'h0);
        end
        m_req <= 1'b0;
        m_sel <= 1'b1;
        @(posedge clk);
        wbuf_en <= 1'b1;
        mx(1'b1, 26'h100, 2'h0, $urandom);
        mx(1'b1, 26'h105, 2'h0, $urandom);
        mx(1'b1, 26'h10a, 2'h1, $urandom);
        n = u_mem.n_wr;
        mx(1'b1, 26'h200, 2'h2, $urandom);
        repeat (20) @(posedge clk);
        chk_n(u_mem.n_wr, n + 1);
        chk_d(32'(u_mem.last_mask), 32'h0c21);
        mx(1'b0, 26'h200, 2'h2, 32'h0);
        chk_n(u_mem.wr_at_rd, n + 2);
        mx(1'b0, 26'h108, 2'h2, 32'h0);
        $display("test merge done");
        flush_timeout <= 8'h20;
        mx(1'b1, 26'h300, 2'h1, $urandom);
        repeat (20) @(posedge clk);
        n = u_mem.n_wr;
        mx(1'b1, 26'h302, 2'h1, $urandom);
        repeat (20) @(posedge clk);
        chk_n(u_mem.n_wr, n);
        repeat (40) @(posedge clk);
        chk_n(u_mem.n_wr, n + 1);
        $display("test flush timer done");
        vr(32'h0410_0000, 1'b0);
        vr(32'h0410_0040, 1'b1);
        vr(32'h0810_0000, 1'b0);
        $display("test video done");
        refresh_en <= 1'b1;
        n = u_mem.n_ref;
        repeat (1000) @(posedge clk);
        chk_n((u_mem.n_ref - n + 2) / 4, 5);
        $display("test refresh done");
        for (it = 0; it < 300; it++)
        begin
            slow <= 1'($urandom_range(1, 0));
            flush_timeout <= 8'($urandom_range(40, 0));
            sz = 2'($urandom_range(2, 0));
            ad = 26'($urandom_range(1023, 0)) & ~26'(sz == 2'h2 ? 3 : sz);
            vgo = $urandom_range(7, 0) == 0;
            va = {6'h01, 6'h01, 14'($urandom), 6'h0};
            fork
                mx(1'($urandom_range(1, 0)), ad, sz, $urandom);
                if (vgo)
                    vr(va, 1'b0);
            join
        end
        $display("test random traffic done");
        end_sim;
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        end_sim;
    end
endmodule : testbench
bind sfe_front_end sfe_props #(.VID_REGION(VID_REGION)) u_props (.*);
